/* core/mswd_regs.svh */
// Register map, field positions, reset values and timing figures of the watchdog
`ifndef MSWD_REGS_SVH
`define MSWD_REGS_SVH
// What this block does
// RULE1 - Factor 01h to FFh arms; periods span about half a minute to 255 minutes
// RULE2 - Period in seconds is 30 plus 60 times (factor minus one)
// RULE3 - Each factor unit stands for about one minute of countdown
// RULE4 - Software arms by writing a nonzero factor byte; counting starts then
// RULE5 - Every trigger write reloads a nonzero count and restarts counting
// RULE6 - Expiry while armed, untouched by trigger or disable, pulses system reset
// RULE7 - Software rewrites the arming factor at least once per period
// RULE8 - A new nonzero factor may come anytime; its period applies at once; the code ignores one written during the reset pulse
// RULE9 - Writing zero stops counting and disarms; no reset follows
// RULE10 - After any reset the watchdog is disarmed and idle
// RULE11 - Indicator blinks while armed and stays off while disarmed
// RULE12 - One-second tick from prescaler; reset pulse lasts fixed cycles, then disarm

`define MSWD_ADDR_W          4
`define MSWD_FACTOR_OFS      4'h0
`define MSWD_STATUS_OFS      4'h4
`define MSWD_IRQ_STAT_OFS    4'h8
`define MSWD_IRQ_MASK_OFS    4'hC
`define MSWD_FACTOR_RST      8'h00
`define MSWD_IRQ_MASK_RST    3'h0
`define MSWD_STAT_ARMED_BIT  0
`define MSWD_STAT_RSTACT_BIT 1
`define MSWD_STAT_FACTOR_LSB 8
`define MSWD_STAT_REMAIN_LSB 16
`define MSWD_IRQ_W           3
`define MSWD_IRQ_EXPIRED_BIT 0
`define MSWD_IRQ_TRIGGER_BIT 1
`define MSWD_IRQ_DISARM_BIT  2
`define MSWD_BASE_S          30
`define MSWD_STEP_S          60
`define MSWD_CLK_HZ          100000000
`define MSWD_CLK_PERIOD_NS   10
`define MSWD_BLINK_HALF_MS   500
`define MSWD_RST_PULSE_NS    1000
`define MSWD_RST_PULSE_CYC   ((`MSWD_RST_PULSE_NS + `MSWD_CLK_PERIOD_NS - 1) / `MSWD_CLK_PERIOD_NS)
`define MSWD_BLINK_HALF_CYC  ((`MSWD_CLK_HZ / 1000) * `MSWD_BLINK_HALF_MS)
`endif

/* core/mswd_pkg.sv */
// Types and period arithmetic shared by the watchdog top module and its bench
`include "mswd_regs.svh"
package mswd_pkg;
   typedef logic [31:0]               mswd_word_type;
   typedef logic [`MSWD_ADDR_W-1:0]   mswd_addr_type;
   typedef logic [7:0]                mswd_factor_type;
   typedef logic [13:0]               mswd_secs_type;
   typedef logic [`MSWD_IRQ_W-1:0]    mswd_irq_type;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RESET} mswd_state_type;

   // Seconds of countdown for a nonzero factor
   function automatic mswd_secs_type mswd_period_f(input mswd_factor_type f);
      int s;
      s = `MSWD_BASE_S + `MSWD_STEP_S * (int'(f) - 1);
      return mswd_secs_type'(s);
   endfunction
endpackage

/* core/mswd_tick_if.sv */
// Signals between the watchdog core, its prescaler and its indicator blinker
`timescale 1ns/100ps
interface mswd_tick_if;
   logic run;
   logic restart;
   logic sec_tick;
   logic led;
   modport core      (output run, output restart, input sec_tick, input led);
   modport prescaler (input run, input restart, output sec_tick);
   modport blinker   (input run, output led);
endinterface

/* core/mswd_prescaler.sv */
// One-second tick generator, restarted on every trigger write
`timescale 1ns/100ps
module mswd_prescaler #(
   parameter int TICK_CYC = 100000000
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   mswd_tick_if.prescaler tk
);
   localparam int W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   localparam logic [W-1:0] LAST = W'(TICK_CYC - 1);
   logic [W-1:0] cnt_r;
   logic         tick_r;

   initial begin
      if (TICK_CYC < 2) $error("TICK_CYC must be at least 2");
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else if (!tk.run || tk.restart) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else if (cnt_r == LAST) begin
         cnt_r  <= '0;
         tick_r <= 1'b1; // RULE12
      end else begin
         cnt_r  <= cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end
   assign tk.sec_tick = tick_r;
endmodule // mswd_prescaler

/* core/mswd_blinker.sv */
// Activity indicator blinker, dark while the watchdog is not armed
`timescale 1ns/100ps
module mswd_blinker #(
   parameter int HALF_CYC = 50000000
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   mswd_tick_if.blinker tk
);
   localparam int W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
   localparam logic [W-1:0] LAST = W'(HALF_CYC - 1);
   logic [W-1:0] cnt_r;
   logic         led_r;

   initial begin
      if (HALF_CYC < 2) $error("HALF_CYC must be at least 2");
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
         led_r <= 1'b0;
      end else if (!tk.run) begin
         cnt_r <= '0;
         led_r <= 1'b0; // RULE11
      end else if (cnt_r == LAST) begin
         cnt_r <= '0;
         led_r <= ~led_r; // RULE11
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
   assign tk.led = led_r;
endmodule // mswd_blinker

/* core/mswd_top.sv */
// Minute-scale watchdog with classic Wishbone register access
`timescale 1ns/100ps
`include "mswd_regs.svh"
module mswd_top #(
   parameter int CLK_HZ         = `MSWD_CLK_HZ,
   parameter int BLINK_HALF_CYC = `MSWD_BLINK_HALF_CYC,
   parameter int RST_PULSE_CYC  = `MSWD_RST_PULSE_CYC
) (
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_n_i,
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire mswd_pkg::mswd_addr_type wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire mswd_pkg::mswd_word_type wb_dat_i,
   output mswd_pkg::mswd_word_type      wb_dat_o,
   output logic                         wb_ack_o,
   output logic                         irq_o,
   output logic                         sys_rst_o,
   output logic                         activity_indicator_o
);
   import mswd_pkg::*;

   localparam int RST_PULSE_M1 = RST_PULSE_CYC - 1;
   localparam logic [8:0] PULSE_LAST = 9'(RST_PULSE_M1);

   initial begin
      if (CLK_HZ < 2) $error("CLK_HZ must be at least 2");
      if (RST_PULSE_CYC < 2 || RST_PULSE_CYC > 300) $error("RST_PULSE_CYC out of 2..300");
      if (BLINK_HALF_CYC < 2) $error("BLINK_HALF_CYC must be at least 2");
   end

   mswd_tick_if tk ();

   mswd_prescaler #(
      .TICK_CYC (CLK_HZ)
   ) u_prescaler (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .tk        (tk)
   );

   mswd_blinker #(
      .HALF_CYC (BLINK_HALF_CYC)
   ) u_blinker (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .tk        (tk)
   );

   mswd_state_type  state_r;
   mswd_secs_type   remain_r;
   mswd_factor_type factor_r;
   logic [8:0]      pulse_cnt_r;
   logic            sys_rst_r;
   logic            ack_r;
   mswd_word_type   dat_r;
   mswd_irq_type    irq_stat_r;
   mswd_irq_type    irq_mask_r;
   logic            irq_r;
   logic            led_r;

   // Bus request phases: first edge answers, edge with ack commits a write
   logic            req_new;
   logic            wr_commit;
   logic            fac_wr;
   mswd_factor_type fac_din;
   logic            armed;
   logic            expire;
   logic            ev_trigger;
   logic            ev_disarm;
   mswd_irq_type    ev_vec;
   mswd_irq_type    clr_vec;

   assign req_new   = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr_commit = wb_cyc_i && wb_stb_i && ack_r && wb_we_i;
   assign fac_wr    = wr_commit && (wb_adr_i == `MSWD_FACTOR_OFS) && wb_sel_i[0];
   assign fac_din   = wb_dat_i[7:0];
   assign armed     = (state_r == ST_ARMED);

   // Expiry only when no trigger or disable write lands in the same cycle
   assign expire     = armed && tk.sec_tick && (remain_r == 14'h0001) && !fac_wr; // RULE6
   assign ev_trigger = fac_wr && (fac_din != 8'h00) && (state_r != ST_RESET);
   assign ev_disarm  = fac_wr && (fac_din == 8'h00) && armed;

   assign tk.run     = armed;
   assign tk.restart = fac_wr; // RULE5

   // Countdown state machine
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r     <= ST_IDLE; // RULE10
         remain_r    <= '0;
         factor_r    <= `MSWD_FACTOR_RST;
         pulse_cnt_r <= '0;
         sys_rst_r   <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (fac_wr && fac_din != 8'h00) begin
                  state_r  <= ST_ARMED; // RULE4 RULE1
                  remain_r <= mswd_period_f(fac_din); // RULE2 RULE3
                  factor_r <= fac_din;
               end
            end
            ST_ARMED: begin
               if (fac_wr) begin
                  if (fac_din == 8'h00) begin
                     state_r  <= ST_IDLE; // RULE9
                     remain_r <= '0;
                     factor_r <= 8'h00;
                  end else begin
                     remain_r <= mswd_period_f(fac_din); // RULE5 RULE8
                     factor_r <= fac_din;
                  end
               end else if (expire) begin
                  state_r     <= ST_RESET;
                  remain_r    <= '0;
                  pulse_cnt_r <= '0;
                  sys_rst_r   <= 1'b1; // RULE6
               end else if (tk.sec_tick) begin
                  remain_r <= remain_r - 14'h0001; // RULE12
               end
            end
            ST_RESET: begin
               if (pulse_cnt_r == PULSE_LAST) begin
                  state_r   <= ST_IDLE; // RULE12
                  sys_rst_r <= 1'b0;
                  factor_r  <= 8'h00;
               end else begin
                  pulse_cnt_r <= pulse_cnt_r + 9'h001;
               end
            end
            default: begin
               state_r   <= ST_IDLE;
               sys_rst_r <= 1'b0;
            end
         endcase
      end
   end

   // Wishbone acknowledge and read data
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_r <= 1'b0;
         dat_r <= '0;
      end else begin
         ack_r <= req_new;
         if (req_new && !wb_we_i) begin
            case (wb_adr_i)
               `MSWD_STATUS_OFS: begin
                  dat_r <= '0;
                  dat_r[`MSWD_STAT_ARMED_BIT]  <= armed;
                  dat_r[`MSWD_STAT_RSTACT_BIT] <= sys_rst_r;
                  dat_r[`MSWD_STAT_FACTOR_LSB +: 8]  <= factor_r;
                  dat_r[`MSWD_STAT_REMAIN_LSB +: 14] <= remain_r;
               end
               `MSWD_IRQ_STAT_OFS: dat_r <= {29'h0, irq_stat_r};
               `MSWD_IRQ_MASK_OFS: dat_r <= {29'h0, irq_mask_r};
               default:            dat_r <= '0;
            endcase
         end else if (!req_new) begin
            dat_r <= '0;
         end
      end
   end

   // Interrupt status, sticky; a set in the clearing cycle wins
   always_comb begin
      ev_vec = '0;
      ev_vec[`MSWD_IRQ_EXPIRED_BIT] = expire;
      ev_vec[`MSWD_IRQ_TRIGGER_BIT] = ev_trigger;
      ev_vec[`MSWD_IRQ_DISARM_BIT]  = ev_disarm;
      clr_vec = '0;
      if (wr_commit && wb_adr_i == `MSWD_IRQ_STAT_OFS && wb_sel_i[0]) begin
         clr_vec = wb_dat_i[`MSWD_IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~clr_vec) | ev_vec;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_mask_r <= `MSWD_IRQ_MASK_RST;
      end else if (wr_commit && wb_adr_i == `MSWD_IRQ_MASK_OFS && wb_sel_i[0]) begin
         irq_mask_r <= wb_dat_i[`MSWD_IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_r <= 1'b0;
         led_r <= 1'b0;
      end else begin
         irq_r <= |(irq_stat_r & irq_mask_r);
         led_r <= tk.led; // RULE11
      end
   end

   assign wb_dat_o             = dat_r;
   assign wb_ack_o             = ack_r;
   assign irq_o                = irq_r;
   assign sys_rst_o            = sys_rst_r;
   assign activity_indicator_o = led_r;

   // Helper counters for the checks below
   logic [8:0]      pulse_len_r;
   logic [31:0]     blink_age_r;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_len_r <= '0;
      end else if (sys_rst_r) begin
         pulse_len_r <= pulse_len_r + 9'h001;
      end else begin
         pulse_len_r <= '0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         blink_age_r <= '0;
      end else if (!armed || (led_r != tk.led)) begin
         blink_age_r <= '0;
      end else begin
         blink_age_r <= blink_age_r + 32'h0000_0001;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   sequence seq_arm_write;
      fac_wr && (fac_din != 8'h00) && (state_r != ST_RESET);
   endsequence

   sequence seq_zero_write;
      fac_wr && (fac_din == 8'h00) && (state_r != ST_RESET);
   endsequence

   sequence seq_expire;
      armed && tk.sec_tick && (remain_r == 14'h0001) && !fac_wr;
   endsequence

   sequence seq_tick_step;
      armed && tk.sec_tick && !fac_wr && (remain_r != 14'h0001);
   endsequence

   AST_ARM_RELOAD: assert property ( // RULE4
      seq_arm_write |=> armed && (remain_r == mswd_period_f($past(fac_din))))
      else $error("nonzero factor write did not arm with reload");

   AST_PERIOD_FACTOR1: assert property ( // RULE2
      seq_arm_write ##0 (fac_din == 8'h01) |=> (remain_r == 14'd30))
      else $error("factor one did not give thirty seconds");

   AST_ZERO_DISARMS: assert property ( // RULE9
      seq_zero_write |=> !armed ##1 !sys_rst_o)
      else $error("zero write did not disarm");

   AST_NO_RESET_IDLE: assert property ( // RULE9
      (state_r == ST_IDLE) && !sys_rst_o |=> !sys_rst_o)
      else $error("reset pulse while disarmed");

   AST_EXPIRE_PULSE: assert property ( // RULE6
      seq_expire |=> sys_rst_o && (state_r == ST_RESET))
      else $error("expiry did not raise reset pulse");

   AST_PULSE_LEN: assert property ( // RULE12
      $fell(sys_rst_o) |-> (pulse_len_r == 9'(RST_PULSE_CYC)) && !armed)
      else $error("reset pulse length wrong");

   AST_PULSE_CAUSE: assert property ( // RULE6
      $rose(sys_rst_o) |-> $past(armed) && ($past(remain_r) == 14'h0001))
      else $error("reset pulse without expiry");

   AST_LED_DARK: assert property ( // RULE11
      !armed ##1 !armed |=> !activity_indicator_o)
      else $error("indicator lit while disarmed");

   AST_TICK_ARMED: assert property ( // RULE12
      tk.sec_tick |-> armed || $past(armed))
      else $error("second tick while not armed");

   AST_IRQ_LEVEL: assert property (
      ((irq_stat_r & irq_mask_r) != '0) |=> irq_o)
      else $error("unmasked status did not raise interrupt");

   AST_ACK_ONE: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");

   AST_PULSE_BOUND: assert property ( // RULE12
      sys_rst_o |-> (pulse_len_r < 9'(RST_PULSE_CYC)))
      else $error("reset pulse longer than set");

   AST_TRIG_FLAG: assert property ( // RULE4
      seq_arm_write |=> irq_stat_r[`MSWD_IRQ_TRIGGER_BIT])
      else $error("trigger write not flagged");

   AST_DISARM_FLAG: assert property ( // RULE9
      seq_zero_write ##0 armed |=> irq_stat_r[`MSWD_IRQ_DISARM_BIT])
      else $error("disarm not flagged");

   AST_EXPIRE_FLAG: assert property ( // RULE6
      seq_expire |=> irq_stat_r[`MSWD_IRQ_EXPIRED_BIT])
      else $error("expiry not flagged");

   AST_ARMED_NONZERO: assert property ( // RULE5
      armed |-> (remain_r != 14'h0000))
      else $error("armed with zero count");

   AST_TICK_STEP: assert property ( // RULE3
      seq_tick_step |=> armed && (remain_r == $past(remain_r) - 14'h0001))
      else $error("second tick did not count down by one");

   AST_HOLD_COUNT: assert property ( // RULE2
      armed && !tk.sec_tick && !fac_wr |=> armed && (remain_r == $past(remain_r)))
      else $error("count moved without a tick");

   AST_NEW_FACTOR: assert property ( // RULE8
      seq_arm_write |=> (factor_r == $past(fac_din)))
      else $error("new factor not adopted");

   AST_IDLE_STAYS: assert property ( // RULE10
      (state_r == ST_IDLE) && !fac_wr |=>
         (state_r == ST_IDLE) && (remain_r == 14'h0000) && (factor_r == 8'h00))
      else $error("disarmed watchdog left idle without a write");

   AST_LED_RISE: assert property ( // RULE11
      $rose(activity_indicator_o) |-> $past(armed, 2))
      else $error("indicator lit without being armed");

   AST_BLINK_PERIOD: assert property ( // RULE11
      armed |-> (blink_age_r <= 32'(BLINK_HALF_CYC)))
      else $error("indicator stopped blinking while armed");

   AST_ACK_ANSWER: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");

   AST_DAT_IDLE: assert property (
      !wb_ack_o |-> (wb_dat_o == '0))
      else $error("read data not zero outside ack");

   AST_RESET_NO_ARM: assert property ( // RULE12
      (state_r == ST_RESET) |=> !armed && (sys_rst_o || (factor_r == 8'h00)))
      else $error("reset pulse did not end disarmed");

endmodule // mswd_top

/* test/mswd_top_tb.sv */
// Self-checking bench for the minute-scale watchdog over classic Wishbone
`timescale 1ns/100ps
`include "mswd_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("mismatch at %0t: got %0h exp %0h", $time, (g), (e)); end end
module mswd_top_tb;
   import mswd_pkg::*;
   localparam int TICK    = 20;
   localparam int BLINK   = 4;
   localparam int PULSE   = 8;
   localparam int CEILING = 30000;

   logic          clk_sys_i = 1'b0;
   logic          rst_n_i   = 1'b0;
   logic          cyc       = 1'b0;
   logic          stb       = 1'b0;
   logic          we        = 1'b0;
   mswd_addr_type adr       = '0;
   logic [3:0]    sel       = 4'h0;
   mswd_word_type dat       = '0;
   mswd_word_type dat_o;
   logic          ack;
   logic          irq;
   logic          sys_rst;
   logic          led;
   int            mismatches  = 0;
   int            check_count = 0;
   int            cyc_count   = 0;
   int            pulse_cyc   = 0;
   int            n;
   mswd_word_type q;

   mswd_top #(.CLK_HZ(TICK), .BLINK_HALF_CYC(BLINK), .RST_PULSE_CYC(PULSE)) mswd_top_i (
      .clk_sys_i            (clk_sys_i),
      .rst_n_i              (rst_n_i),
      .wb_cyc_i             (cyc),
      .wb_stb_i             (stb),
      .wb_we_i              (we),
      .wb_adr_i             (adr),
      .wb_sel_i             (sel),
      .wb_dat_i             (dat),
      .wb_dat_o             (dat_o),
      .wb_ack_o             (ack),
      .irq_o                (irq),
      .sys_rst_o            (sys_rst),
      .activity_indicator_o (led)
   );

   always #5 clk_sys_i = ~clk_sys_i;

   always @(posedge clk_sys_i) begin
      cyc_count++;
      if (sys_rst === 1'b1) begin
         pulse_cyc++;
      end
      if (cyc_count == CEILING) begin
         mismatches++;
         complete_run();
      end
   end

   task automatic wb_xfer(input logic w, input mswd_addr_type a, input mswd_word_type d,
                          output mswd_word_type r);
      @(posedge clk_sys_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk_sys_i);
      end while (ack !== 1'b1);
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input mswd_addr_type a, input mswd_word_type d);
      mswd_word_type r;
      wb_xfer(1'b1, a, d, r);
   endtask

   task automatic rd(input mswd_addr_type a, output mswd_word_type r);
      wb_xfer(1'b0, a, '0, r);
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clk_sys_i);
   endtask

   function automatic mswd_word_type armed_stat(input int f);
      return {2'b00, 14'(`MSWD_BASE_S + `MSWD_STEP_S * (f - 1)), 8'(f), 8'h01};
   endfunction

   task automatic end_test(input string name);
      $display("test %s done, %0d mismatches so far", name, mismatches);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      idle(6);
      rst_n_i <= 1'b1;
      // Reset state and unmapped address
      rd(`MSWD_STATUS_OFS, q);   `CHK(q, 32'h0)
      rd(`MSWD_IRQ_MASK_OFS, q); `CHK(q, 32'h0)
      rd(`MSWD_FACTOR_OFS, q);   `CHK(q, 32'h0)
      wr(4'h2, 32'h0000_00FF);
      rd(4'h2, q);               `CHK(q, 32'h0)
      rd(`MSWD_STATUS_OFS, q);   `CHK(q, 32'h0)
      `CHK({irq, sys_rst, led}, 3'b000)
      end_test("reset");
      // Arm, blink, interrupt mask and clear
      wr(`MSWD_FACTOR_OFS, 32'h01);
      rd(`MSWD_STATUS_OFS, q);   `CHK(q, armed_stat(1))
      rd(`MSWD_IRQ_STAT_OFS, q); `CHK(q[`MSWD_IRQ_TRIGGER_BIT], 1'b1)
      idle(2);
      `CHK(irq, 1'b0)
      n = 0;
      repeat (8 * BLINK) begin
         @(posedge clk_sys_i);
         if (led === 1'b1) n++;
      end
      `CHK(n, 4 * BLINK)
      wr(`MSWD_IRQ_MASK_OFS, 32'h02);
      idle(2);
      `CHK(irq, 1'b1)
      wr(`MSWD_IRQ_STAT_OFS, 32'h02);
      idle(2);
      `CHK(irq, 1'b0)
      rd(`MSWD_IRQ_MASK_OFS, q); `CHK(q, 32'h2)
      end_test("arm");
      // Retrigger late in the period, then change factor
      idle(25 * TICK);
      wr(`MSWD_FACTOR_OFS, 32'h01);
      rd(`MSWD_STATUS_OFS, q);   `CHK(q, armed_stat(1))
      idle(25 * TICK);
      `CHK(sys_rst, 1'b0)
      wr(`MSWD_FACTOR_OFS, 32'h02);
      rd(`MSWD_STATUS_OFS, q);   `CHK(q, armed_stat(2))
      wr(`MSWD_FACTOR_OFS, 32'hFF);
      rd(`MSWD_STATUS_OFS, q);   `CHK(q, armed_stat(255))
      end_test("retrigger");
      // Disarm by zero write: no reset afterwards
      wr(`MSWD_FACTOR_OFS, 32'h00);
      rd(`MSWD_STATUS_OFS, q);   `CHK(q, 32'h0)
      rd(`MSWD_IRQ_STAT_OFS, q); `CHK(q[`MSWD_IRQ_DISARM_BIT], 1'b1)
      wr(`MSWD_IRQ_STAT_OFS, 32'h07);
      idle(32 * TICK);
      `CHK({sys_rst, led}, 2'b00)
      `CHK(pulse_cyc, 0)
      end_test("disarm");
      // Expiry timing, pulse width, write ignored during pulse
      wr(`MSWD_IRQ_MASK_OFS, 32'h01);
      wr(`MSWD_FACTOR_OFS, 32'h01);
      pulse_cyc = 0;
      n = 0;
      while (sys_rst !== 1'b1 && n < 40 * TICK) begin
         @(posedge clk_sys_i);
         n++;
      end
      `CHK(n >= 30 * TICK - 2 && n <= 30 * TICK + 3, 1'b1)
      wr(`MSWD_FACTOR_OFS, 32'h05);
      n = 0;
      while (sys_rst !== 1'b0 && n < 400) begin
         @(posedge clk_sys_i);
         n++;
      end
      idle(2);
      `CHK(pulse_cyc, PULSE)
      rd(`MSWD_STATUS_OFS, q);   `CHK(q, 32'h0)
      rd(`MSWD_IRQ_STAT_OFS, q); `CHK(q[`MSWD_IRQ_EXPIRED_BIT], 1'b1)
      `CHK(irq, 1'b1)
      wr(`MSWD_IRQ_STAT_OFS, 32'h01);
      idle(2);
      `CHK({irq, led}, 2'b00)
      end_test("expiry");
      // Second reset in mid-run while armed
      wr(`MSWD_FACTOR_OFS, 32'h03);
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      idle(6);
      rst_n_i <= 1'b1;
      rd(`MSWD_STATUS_OFS, q);   `CHK(q, 32'h0)
      `CHK({irq, sys_rst, led}, 3'b000)
      end_test("rereset");
      complete_run();
   end
endmodule // mswd_top_tb
